// ===== include/evt_map.vh
// Register offsets, bit positions and timing counts for the event block
`ifndef EVT_MAP_VH
`define EVT_MAP_VH

// Register addresses on the management path
`define EVT_STATUS_ADDR      8'hAE
`define EVT_MASK_ADDR        8'hAF

// Event bit positions
`define EVT_BIT_SPEED        0
`define EVT_BIT_SOURCE_ADDR_CHANGE_FLAG    1
`define EVT_BIT_FALSE_CAR    2
`define EVT_BIT_PARTITION    3
`define EVT_BIT_ISOLATE      4
`define EVT_BIT_JABBER       5
`define EVT_BIT_FAR_FAULT    7

// Implemented bits; 31:8 and 6 read as zero
`define EVT_IMPL_MASK        32'h0000_00BF
`define EVT_RESET_VALUE      32'h0000_0000

// Limits in bit times and events
`define JAB_100_BITS         57500
`define JAB_10_BITS          40000
`define JAB_10_MAX_BITS      75000
`define ISO_FALSE_LIMIT      2
`define PART_100_LIMIT       60
`define PART_10_LIMIT        32
`define FAR_FLP_LIMIT        3

// Minimum idle gap, in bit times
`define IFG_BITS             96

`endif

// ===== verilog/repeater_event_status_mask.v
// Repeater event detection with sticky status and mask registers
//
// Functional notes
// RULE_01: Clear-mode zero: status read returns data, then clears all bits.
// RULE_02: With clear-mode one, reads keep bits; writing one clears that bit.
// RULE_03: Mask: one bit per event; zero passes, one masks; resets to zero.
// RULE_04: Status captures each event, holds it until cleared; resets zero.
// RULE_05: Bit 7 sets on received fault code or three remote-fault bursts.
// RULE_06: Bit 7 sets on local PLL/signal loss or sending remote-fault bursts.
// RULE_07: Bit 5 sets at 100 Mbps when a receiver is active over 57,500 bits.
// RULE_08: At 100 Mbps jabber ends only when all receivers are idle.
// RULE_09: At 10 Mbps jabber when a port transmits beyond 40,000..75,000 bits.
// RULE_10: 10 Mbps jabber forces an idle of at least the interframe gap.
// RULE_11: At 100 Mbps, isolate on over two false carriers in a row; bit 4.
// RULE_12: A packet not starting with the J/K pair counts as a false carrier.
// RULE_13: At 100 Mbps, partition after over 60 collisions in a row; bit 3.
// RULE_14: At 10 Mbps, partition after over 32 collisions in a row; bit 3.
// RULE_15: Partitioned ports stay monitored and fed; receive is not repeated.
// RULE_16: Bit 2 sets when a port received too many false carriers.
// RULE_17: Bit 1 sets when a source address differs from the tracked address.
// RULE_18: Bit 0 sets on any port speed change.
// RULE_19: Bits 31:8 and 6 are written as zero and read back as zero.
// RULE_20: Interrupt output high while any unmasked status bit is set.
// RULE_21: An event in the same cycle as its clear keeps the bit set.
`timescale 1ns/1ps
`default_nettype none
`include "evt_map.vh"

module repeater_event_status_mask #(
  parameter NPORT = 5,                        // Number of ports
  parameter JAB100 = `JAB_100_BITS,           // 100 Mbps jabber, bit times
  parameter JAB10  = `JAB_10_BITS,            // 10 Mbps jabber, bit times
  parameter INTERFRAME_GAP    = `IFG_BITS                // Forced idle, bit times
) (
  input  wire             mclk_i,             // 125 MHz clock
  input  wire             sys_rst_i,          // Synchronous reset, high
  input  wire             clr_mode_i,         // Clear mode: 0 read, 1 W1C
  input  wire [7:0]       reg_addr_i,         // Register address
  input  wire             reg_rd_i,           // Read strobe, one cycle
  input  wire             reg_wr_i,           // Write strobe, one cycle
  input  wire [31:0]      reg_wdata_i,        // Write data
  output reg  [31:0]      reg_rdata_o,        // Read data, next cycle
  input  wire             speed100_i,         // Repeater runs at 100 Mbps
  input  wire             bit_tick_i,         // One pulse per bit time
  input  wire [NPORT-1:0] rx_active_i,        // Receiver carrier per port
  input  wire [NPORT-1:0] tx_active_i,        // Transmitter active per port
  input  wire [NPORT-1:0] pkt_start_i,        // Start of received packet
  input  wire [NPORT-1:0] jk_ok_i,            // Start had J then K pair
  input  wire [NPORT-1:0] coll_end_i,         // Collision at end of packet
  input  wire [NPORT-1:0] clean_end_i,        // Packet ended without collision
  input  wire [NPORT-1:0] fiber_rf_code_i,    // Fiber got remote fault code
  input  wire [NPORT-1:0] flp_rf_rx_i,        // Burst received with RF bit
  input  wire [NPORT-1:0] flp_rx_i,           // Any burst received
  input  wire [NPORT-1:0] fiber_lost_i,       // PLL unlock or no signal
  input  wire [NPORT-1:0] flp_rf_tx_i,        // Sending bursts with RF bit
  input  wire [NPORT-1:0] excess_false_car_i, // Excess false carrier seen
  input  wire [NPORT-1:0] source_addr_change_flag_i,        // Address differs from tracked
  input  wire [NPORT-1:0] speed_change_i,     // Port speed changed
  output reg              jabber_o,           // Jabber state
  output reg              force_idle_o,       // Forced idle gap active
  output reg  [NPORT-1:0] isolated_o,         // Port isolated
  output reg  [NPORT-1:0] partitioned_o,      // Port partitioned
  output wire [NPORT-1:0] rx_repeat_o,        // Receive may be repeated
  output wire             irq_o               // Unmasked event pending
);

  // ************************************************************
  // Local state
  // ************************************************************
  reg  [31:0] event_status;
  reg  [31:0] event_mask;
  reg  [16:0] jab_cnt;
  reg  [16:0] ifg_cnt;
  // Run counters per port
  reg  [1:0]  false_run  [0:NPORT-1];
  reg  [6:0]  coll_run   [0:NPORT-1];
  reg  [1:0]  flp_run    [0:NPORT-1];
  reg  [NPORT-1:0] far_hit;
  reg  [NPORT-1:0] next_iso;
  reg  [NPORT-1:0] next_part;
  reg  [31:0] events;
  reg  [31:0] clr;
  reg  [31:0] next_status;
  wire [6:0]  part_lim;
  wire        jab_busy;
  wire        jab_set;
  // Register bus decodes
  wire        st_rd;
  wire        st_wr;
  wire        mk_rd;
  wire        mk_wr;
  reg  [31:0] next_rdata;
  integer     i;
  integer     j;

  // Saturating increment for small counters
  function [6:0] sat_inc;
    input [6:0] v;
    begin
      sat_inc = (v == 7'h7F) ? v : v + 7'h01;
    end
  endfunction

  // Saturating increment for two-bit run counters
  function [1:0] sat_inc2;
    input [1:0] v;
    begin
      sat_inc2 = (v == 2'b11) ? v : v + 2'b01;
    end
  endfunction

  // Register address match on the management path
  function addr_hit;
    input [7:0] a;
    input [7:0] target;
    begin
      addr_hit = (a == target);
    end
  endfunction

  // ************************************************************
  // Jabber detection
  // ************************************************************
  // Collision limit and jabber trigger for the current speed
  assign part_lim = speed100_i ? 7'd`PART_100_LIMIT : 7'd`PART_10_LIMIT;
  assign jab_busy = speed100_i ? |rx_active_i : |tx_active_i;
  assign jab_set  = jab_busy && bit_tick_i &&
                    (jab_cnt == (speed100_i ? JAB100 : JAB10)); // [RULE_07]

  // Bit-time counter, jabber state and forced idle gap
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      jab_cnt      <= 17'h00000;
      ifg_cnt      <= 17'h00000;
      jabber_o     <= 1'b0;
      force_idle_o <= 1'b0;
    end
    else
    begin
      if (!jab_busy)
        jab_cnt <= 17'h00000;
      else if (bit_tick_i && !jab_set)
        jab_cnt <= jab_cnt + 17'h00001;
      if (jab_set)
        jabber_o <= 1'b1;                     // [RULE_07] [RULE_09]
      else if (speed100_i && !(|rx_active_i))
        jabber_o <= 1'b0;                     // [RULE_08]
      else if (!speed100_i && !force_idle_o && ifg_cnt == INTERFRAME_GAP)
        jabber_o <= 1'b0;
      // Idle gap while 10 Mbps jabber holds
      if (jab_set && !speed100_i)
      begin
        force_idle_o <= 1'b1;                 // [RULE_10]
        ifg_cnt      <= 17'h00000;
      end
      else if (force_idle_o && bit_tick_i)
      begin
        if (ifg_cnt == INTERFRAME_GAP - 1)
          force_idle_o <= 1'b0;               // [RULE_10]
        ifg_cnt <= ifg_cnt + 17'h00001;
      end
    end
  end

  // ************************************************************
  // Per-port isolation, partition and far-end fault
  // ************************************************************
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      isolated_o    <= {NPORT{1'b0}};
      partitioned_o <= {NPORT{1'b0}};
      far_hit       <= {NPORT{1'b0}};
      for (i = 0; i < NPORT; i = i + 1)
      begin
        false_run[i] <= 2'b00;
        coll_run[i]  <= 7'h00;
        flp_run[i]   <= 2'b00;
      end
    end
    else
    begin
      isolated_o    <= next_iso;
      partitioned_o <= next_part;
      for (i = 0; i < NPORT; i = i + 1)
      begin
        // Packet start without J/K is a false carrier
        if (pkt_start_i[i] && !jk_ok_i[i])    // [RULE_12]
          false_run[i] <= sat_inc2(false_run[i]);
        else if (pkt_start_i[i])
          false_run[i] <= 2'b00;
        // Consecutive collision run
        if (coll_end_i[i])
          coll_run[i] <= sat_inc(coll_run[i]);
        else if (clean_end_i[i])
          coll_run[i] <= 7'h00;
        // Consecutive remote-fault bursts
        if (flp_rf_rx_i[i])
          flp_run[i] <= sat_inc2(flp_run[i]);
        else if (flp_rx_i[i])
          flp_run[i] <= 2'b00;
        far_hit[i] <= fiber_rf_code_i[i] || fiber_lost_i[i] ||
                      flp_rf_tx_i[i] ||
                      (flp_run[i] >= `FAR_FLP_LIMIT - 1 &&
                       flp_rf_rx_i[i]);       // [RULE_05] [RULE_06]
      end
    end
  end

  // Next isolation and partition per port
  always @*
  begin
    next_iso  = isolated_o;
    next_part = partitioned_o;
    for (j = 0; j < NPORT; j = j + 1)
    begin
      // A good start ends isolation even with a full run count
      if (pkt_start_i[j] && jk_ok_i[j])
        next_iso[j] = 1'b0;                   // [RULE_11]
      else if (speed100_i && false_run[j] > `ISO_FALSE_LIMIT)
        next_iso[j] = 1'b1;                   // [RULE_11]
      // A clean end releases before the stale run count is seen
      if (clean_end_i[j] && !tx_active_i[j])
        next_part[j] = 1'b0;                  // [RULE_15]
      else if (coll_run[j] > part_lim)
        next_part[j] = 1'b1;                  // [RULE_13] [RULE_14]
    end
  end

  // Partitioned ports stay monitored, receive is blocked
  assign rx_repeat_o = ~partitioned_o & ~isolated_o; // [RULE_15]

  // ************************************************************
  // Register bus decode
  // ************************************************************
  // Status and mask access strobes
  assign st_rd = reg_rd_i && addr_hit(reg_addr_i, `EVT_STATUS_ADDR);
  assign st_wr = reg_wr_i && addr_hit(reg_addr_i, `EVT_STATUS_ADDR);
  assign mk_rd = reg_rd_i && addr_hit(reg_addr_i, `EVT_MASK_ADDR);
  assign mk_wr = reg_wr_i && addr_hit(reg_addr_i, `EVT_MASK_ADDR);

  // ************************************************************
  // Status and mask registers
  // ************************************************************
  // Event inputs placed at their status bit positions
  always @*
  begin
    events = 32'h0000_0000;
    events[`EVT_BIT_FAR_FAULT] = |far_hit;                    // [RULE_05]
    events[`EVT_BIT_JABBER]    = jabber_o;                    // [RULE_07]
    events[`EVT_BIT_ISOLATE]   = |(next_iso & ~isolated_o);   // [RULE_11]
    events[`EVT_BIT_PARTITION] = |(next_part & ~partitioned_o); // [RULE_13]
    events[`EVT_BIT_FALSE_CAR] = |excess_false_car_i;         // [RULE_16]
    events[`EVT_BIT_SOURCE_ADDR_CHANGE_FLAG] = |source_addr_change_flag_i;                // [RULE_17]
    events[`EVT_BIT_SPEED]     = |speed_change_i;             // [RULE_18]
    // Set beats clear in the same cycle
    next_status = ((event_status & ~clr) | events)
                  & `EVT_IMPL_MASK;           // [RULE_04] [RULE_21] [RULE_19]
  end

  // Clear source: whole register on read, or the written ones
  always @*
  begin
    clr = 32'h0000_0000;
    if (st_rd && !clr_mode_i)
      clr = 32'hFFFF_FFFF;                    // [RULE_01]
    else if (st_wr && clr_mode_i)
      clr = reg_wdata_i;                      // [RULE_02]
  end

  // Read data select, held between reads
  always @*
  begin
    next_rdata = reg_rdata_o;
    if (st_rd)
      next_rdata = event_status;              // [RULE_01] [RULE_02]
    else if (mk_rd)
      next_rdata = event_mask;                // [RULE_03]
    else if (reg_rd_i)
      next_rdata = 32'h0000_0000;             // [RULE_19]
  end

  // Register update and read data
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      event_status <= `EVT_RESET_VALUE;       // [RULE_04]
      event_mask   <= `EVT_RESET_VALUE;       // [RULE_03]
      reg_rdata_o  <= 32'h0000_0000;
    end
    else
    begin
      event_status <= next_status;
      if (mk_wr)
        event_mask <= reg_wdata_i & `EVT_IMPL_MASK; // [RULE_03] [RULE_19]
      reg_rdata_o  <= next_rdata;
    end
  end

  // Interrupt request from unmasked status
  assign irq_o = |(event_status & ~event_mask); // [RULE_20]

endmodule
`default_nettype wire

// ===== test/evt_sva.sv
// Checker for the repeater event status and mask block
`timescale 1ns/1ps
`default_nettype none
`include "evt_map.vh"
module evt_sva #(
  parameter NPORT = 5 // Port count
) (
  input wire logic             mclk_i,             // Clock
  input wire logic             sys_rst_i,          // Reset
  input wire logic             clr_mode_i,         // Clear mode
  input wire logic [7:0]       reg_addr_i,         // Address
  input wire logic             reg_rd_i,           // Read strobe
  input wire logic             reg_wr_i,           // Write strobe
  input wire logic [31:0]      reg_rdata_o,        // Read data
  input wire logic             speed100_i,         // Speed
  input wire logic [NPORT-1:0] rx_active_i,        // Receivers
  input wire logic [NPORT-1:0] excess_false_car_i, // False carrier
  input wire logic [NPORT-1:0] source_addr_change_flag_i,        // Address change
  input wire logic [NPORT-1:0] speed_change_i,     // Speed change
  input wire logic             jabber_o,           // Jabber
  input wire logic [NPORT-1:0] isolated_o,         // Isolated
  input wire logic [NPORT-1:0] partitioned_o,      // Partitioned
  input wire logic [NPORT-1:0] rx_repeat_o,        // Repeat enable
  input wire logic             irq_o               // Interrupt
);
  // Status read and low event pulses
  wire logic rd_st = reg_rd_i && (reg_addr_i == `EVT_STATUS_ADDR);
  wire logic ev = |{speed_change_i, source_addr_change_flag_i, excess_false_car_i};
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  rsv_zero_a:
    assert property ((reg_rdata_o & 32'hFFFFFF40) == 32'h0)
    else $error("reserved bits nonzero");
  spd_set_a:
    assert property (|speed_change_i ##1 rd_st |=> reg_rdata_o[0])
    else $error("speed change lost");
  cor_clr_a:
    assert property (rd_st && !clr_mode_i && !ev ##1 rd_st
      |=> reg_rdata_o[2:0] == 3'h0)
    else $error("read did not clear");
  w1c_keep_a:
    assert property (rd_st && clr_mode_i && !ev && !reg_wr_i ##1 rd_st
      |=> $stable(reg_rdata_o[2:0]))
    else $error("read changed status");
  repeat_gate_a:
    assert property (rx_repeat_o == ~(partitioned_o | isolated_o))
    else $error("repeat enable wrong");
  jab_hold_a:
    assert property (jabber_o && speed100_i && |rx_active_i |=> jabber_o)
    else $error("jabber left early");
  irq_fall_a:
    assert property ($fell(irq_o) |-> $past(reg_rd_i) || $past(reg_wr_i))
    else $error("irq fell without access");
  iso_fast_a:
    assert property ($rose(|isolated_o) |-> $past(speed100_i))
    else $error("isolation at low speed");
  cover property (|partitioned_o);
  cover property (|isolated_o);
  cover property ($rose(jabber_o));
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the repeater event status and mask block
`timescale 1ns/1ps
`default_nettype none
`include "evt_map.vh"
module tb_top;
  localparam NPORT = 5;
  localparam logic [7:0] ST = `EVT_STATUS_ADDR;
  localparam logic [7:0] MK = `EVT_MASK_ADDR;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        clr_mode_i = 1'b0;
  logic        speed100_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [4:0]  pin [14];
  logic [13:0] ff [3] = '{14'h0040, 14'h0200, 14'h0400};
  logic        seen;
  wire  [31:0] reg_rdata_o;
  wire         jabber_o, force_idle_o, irq_o;
  wire  [4:0]  isolated_o, partitioned_o, rx_repeat_o;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #4 mclk_i = ~mclk_i;
  repeater_event_status_mask #(.NPORT(NPORT), .JAB100(20), .JAB10(30),
    .INTERFRAME_GAP(4)) i_repeater_event_status_mask (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .clr_mode_i(clr_mode_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .speed100_i(speed100_i), .bit_tick_i(1'b1),
    .jabber_o(jabber_o), .force_idle_o(force_idle_o),
    .isolated_o(isolated_o), .partitioned_o(partitioned_o),
    .rx_repeat_o(rx_repeat_o), .irq_o(irq_o),
    .rx_active_i(pin[0]), .tx_active_i(pin[1]), .pkt_start_i(pin[2]),
    .jk_ok_i(pin[3]), .coll_end_i(pin[4]), .clean_end_i(pin[5]),
    .fiber_rf_code_i(pin[6]), .flp_rf_rx_i(pin[7]), .flp_rx_i(pin[8]),
    .fiber_lost_i(pin[9]), .flp_rf_tx_i(pin[10]),
    .excess_false_car_i(pin[11]), .source_addr_change_flag_i(pin[12]),
    .speed_change_i(pin[13]));
  task automatic step;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Two back-to-back reads of one address
  task automatic rdn(input logic [7:0] a, input logic [31:0] e0, e1);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step;
    chk(reg_rdata_o, e0);
    step;
    chk(reg_rdata_o, e1);
    reg_rd_i = 1'b0;
    step;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step;
    reg_wr_i = 1'b0;
    step;
  endtask
  // One-cycle pulse on the selected event inputs
  task automatic pulse(input logic [13:0] m, input logic [4:0] p);
    for (int i = 0; i < 14; i++)
      if (m[i])
        pin[i] = p;
    step;
    for (int i = 0; i < 14; i++)
      if (m[i])
        pin[i] = 5'h00;
    step;
  endtask
  task automatic end_sim;
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      $display("unexpected at %0t: timed out", $time);
      end_sim;
    end
  end
  initial
  begin
    for (int i = 0; i < 14; i++)
      pin[i] = 5'h00;
    repeat (12) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    rdn(ST, 32'h0, 32'h0);
    rdn(MK, 32'h0, 32'h0);
    chk({26'h0, irq_o, rx_repeat_o}, 32'h1F);
    pulse(14'h2000, 5'h01);
    pulse(14'h1000, 5'h02);
    pulse(14'h0800, 5'h04);
    chk(32'(irq_o), 32'h1);
    rdn(ST, 32'h07, 32'h0);
    chk(32'(irq_o), 32'h0);
    wr(MK, 32'hFFFFFFFF);
    rdn(MK, 32'hBF, 32'hBF);
    pulse(14'h2000, 5'h01);
    chk(32'(irq_o), 32'h0);
    rdn(ST, 32'h01, 32'h0);
    wr(MK, 32'h0);
    pin[13] = 5'h01;
    rdn(ST, 32'h0, 32'h01);
    pin[13] = 5'h00;
    rdn(ST, 32'h01, 32'h0);
    foreach (ff[i])
    begin
      pulse(ff[i], 5'h08);
      rdn(ST, 32'h80, 32'h0);
    end
    repeat (2) pulse(14'h0180, 5'h08);
    rdn(ST, 32'h0, 32'h0);
    pulse(14'h0180, 5'h08);
    rdn(ST, 32'h80, 32'h0);
    clr_mode_i = 1'b1;
    pulse(14'h3000, 5'h01);
    rdn(ST, 32'h03, 32'h03);
    wr(ST, 32'h1);
    rdn(ST, 32'h02, 32'h02);
    clr_mode_i = 1'b0;
    rdn(ST, 32'h02, 32'h0);
    for (int s = 0; s < 2; s++)
    begin
      speed100_i = s[0];
      repeat (s ? 60 : 32) pulse(14'h0010, 5'h02);
      chk(32'(partitioned_o), 32'h0);
      pulse(14'h0010, 5'h02);
      chk(32'(partitioned_o), 32'h02);
      chk(32'(rx_repeat_o), 32'h1D);
      rdn(ST, 32'h08, 32'h0);
      pulse(14'h0020, 5'h02);
      chk(32'(partitioned_o), 32'h0);
    end
    repeat (2) pulse(14'h0004, 5'h04);
    chk(32'(isolated_o), 32'h0);
    pulse(14'h0004, 5'h04);
    chk(32'(isolated_o), 32'h04);
    chk(32'(rx_repeat_o), 32'h1B);
    rdn(ST, 32'h10, 32'h0);
    pulse(14'h000C, 5'h04);
    chk(32'(isolated_o), 32'h0);
    speed100_i = 1'b0;
    repeat (3) pulse(14'h0004, 5'h04);
    chk(32'(isolated_o), 32'h0);
    pulse(14'h000C, 5'h04);
    speed100_i = 1'b1;
    pin[0] = 5'h03;
    repeat (15) step;
    chk(32'(jabber_o), 32'h0);
    repeat (10) step;
    chk(32'(jabber_o), 32'h1);
    rdn(ST, 32'h20, 32'h20);
    pin[0] = 5'h02;
    repeat (3) step;
    chk(32'(jabber_o), 32'h1);
    pin[0] = 5'h00;
    repeat (3) step;
    chk(32'(jabber_o), 32'h0);
    rdn(ST, 32'h20, 32'h0);
    speed100_i = 1'b0;
    pin[1] = 5'h01;
    repeat (20) step;
    chk(32'(jabber_o), 32'h0);
    seen = 1'b0;
    repeat (15)
    begin
      step;
      seen |= force_idle_o;
    end
    chk(32'(jabber_o), 32'h1);
    chk(32'(seen), 32'h1);
    end_sim;
  end
endmodule
bind repeater_event_status_mask evt_sva #(.NPORT(NPORT)) i_evt_sva (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clr_mode_i(clr_mode_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i),
  .reg_rdata_o(reg_rdata_o), .speed100_i(speed100_i),
  .rx_active_i(rx_active_i), .excess_false_car_i(excess_false_car_i),
  .source_addr_change_flag_i(source_addr_change_flag_i), .speed_change_i(speed_change_i),
  .jabber_o(jabber_o), .isolated_o(isolated_o),
  .partitioned_o(partitioned_o), .rx_repeat_o(rx_repeat_o), .irq_o(irq_o));
`default_nettype wire
